// *** include/resp_pkg.sv ***
// Summary of operation
// - carrier programmable between 46.5 and 64 kHz
// - demodulate sensed voltage synchronously into impedance
// - heavy low-pass before output; host finds peaks
// - software picks lead I, II, III or external
// - exactly one measurement path while enabled, none while disabled
// - chain only measures impedance, never ECG
// - internal mode drives carrier onto sense pins
// - bit 14 bypasses the on-chip amplifier
// - carrier field writable in control register 0x03
// - frequency follows field and high-performance bit
package resp_pkg;
  // ---------------------------------------------------------------
  // register map (index times four is the byte address)
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_ECG_CTRL = 8'h01;
  localparam logic [7:0] IDX_RESP_CTRL = 8'h03;
  localparam logic [7:0] IDX_STATUS = 8'h04;
  localparam logic [7:0] IDX_SAMPLE = 8'h05;
  localparam int ADDR_W = 8;
  localparam int RESP_CTRL_W = 24;
  localparam logic [23:0] RESP_CTRL_RST = 24'h00_0000;

  // ---------------------------------------------------------------
  // respiration control fields, except F_HP, which is bit 0 of the ECG control register
  // ---------------------------------------------------------------
  localparam int F_ENABLE = 0;
  localparam int F_PATH_LO = 1;
  localparam int F_AMP_LO = 3;
  localparam int F_EXT_CAP = 5;
  localparam int F_FREQ_LO = 6;
  localparam int F_AMP_BYPASS = 14;
  localparam int F_HP = 0;

  typedef enum logic [1:0] {PATH_LEAD_I, PATH_LEAD_II, PATH_LEAD_III, PATH_EXTERNAL} path_e;
  typedef enum logic [1:0] {AMP_QUARTER, AMP_HALF, AMP_THREE_Q, AMP_FULL} amp_e;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned HP_FREQ_HZ [4] = '{56000, 54000, 64000, 46500};
  localparam int unsigned LP_FREQ_HZ [4] = '{50000, 48000, 60000, 46500};
  localparam int HALF_W = 16;

  typedef struct packed {
    logic drive_en;
    logic drive_pos;
    logic drive_neg;
    logic [3:0] sense_sel;
    logic [3:0] drive_sel;
    logic ext_cap;
    logic dac_path_en;
    logic amp_bypass;
    logic [1:0] amplitude;
  } analog_ctl_s;

  typedef struct packed {
    logic valid;
    logic signed [15:0] data;
  } sense_s;
endpackage : resp_pkg

// *** src/resp_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
module resp_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int PW = $clog2(DEPTH);
  generate
    if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad
      $error("depth must be a power of two of at least two");
    end
  endgenerate

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic push, pop;

  assign level = wr_r - rd_r;
  assign in_ready = (level != (PW+1)'(DEPTH));
  assign out_valid = (wr_r != rd_r);
  assign out_data = mem_r[rd_r[PW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    wr_nxt = push ? wr_r + 1'b1 : wr_r;
    rd_nxt = pop ? rd_r + 1'b1 : rd_r;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (push) begin
      mem_r[wr_r[PW-1:0]] <= in_data;
    end
  end

  a_fifo_no_over: assert property (@(posedge clock) disable iff (rst) level <= (PW+1)'(DEPTH))
    else $error("fifo level above depth");
endmodule : resp_fifo
`default_nettype wire

// *** src/resp_impedance_ctrl.sv ***
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
module resp_impedance_ctrl #(
  parameter int DECIM = 256,
  parameter int LPF_SHIFT = 3,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire resp_pkg::sense_s sense,
  output resp_pkg::analog_ctl_s analog,
  output logic sample_valid,
  input wire logic sample_ready,
  output logic [31:0] sample_data
);
  generate
    if (DECIM < 2 || DECIM > 65536 || LPF_SHIFT < 1 || LPF_SHIFT > 16) begin : g_bad
      $error("unsupported decimation or filter shift");
    end
  endgenerate

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] half_cycles(input logic [1:0] code, input logic hp);
    int unsigned f;
    f = hp ? resp_pkg::HP_FREQ_HZ[code] : resp_pkg::LP_FREQ_HZ[code];
    return 16'(resp_pkg::CLK_HZ / (2 * f));
  endfunction : half_cycles

  function automatic logic [3:0] path_onehot(input logic [1:0] p);
    return 4'(4'h1 << p);
  endfunction : path_onehot

  typedef enum logic [1:0] {ST_IDLE, ST_SETTLE, ST_RUN} demod_state_e;

  // ---------------------------------------------------------------
  // register bus
  // ---------------------------------------------------------------
  logic [23:0] resp_ctrl_r, resp_ctrl_nxt;
  logic hp_r, hp_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic overflow_r, overflow_nxt;
  logic [31:0] last_sample_r, last_sample_nxt;
  logic [$clog2(FIFO_DEPTH):0] fifo_level;
  logic [5:0] idx;
  logic mapped, setup, access, wr_ctrl, rd_status;
  logic fifo_in_ready, push_ok;
  logic pend_r, pend_nxt;
  logic [31:0] pend_data_r, pend_data_nxt;
  logic dump;

  assign idx = paddr[7:2];
  assign mapped = (paddr[1:0] == 2'b00) &&
                  (idx == resp_pkg::IDX_ECG_CTRL[5:0] || idx == resp_pkg::IDX_RESP_CTRL[5:0] ||
                   idx == resp_pkg::IDX_STATUS[5:0] || idx == resp_pkg::IDX_SAMPLE[5:0]);
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  assign prdata = prdata_r;
  assign wr_ctrl = access && pwrite && mapped && idx == resp_pkg::IDX_RESP_CTRL[5:0];
  assign rd_status = access && !pwrite && mapped && idx == resp_pkg::IDX_STATUS[5:0];

  always_comb begin
    resp_ctrl_nxt = resp_ctrl_r;
    hp_nxt = hp_r;
    prdata_nxt = prdata_r;
    overflow_nxt = overflow_r;
    if (wr_ctrl) begin
      resp_ctrl_nxt = pwdata[resp_pkg::RESP_CTRL_W-1:0];
    end
    if (access && pwrite && mapped && idx == resp_pkg::IDX_ECG_CTRL[5:0]) begin
      hp_nxt = pwdata[resp_pkg::F_HP];
    end
    if (setup) begin
      case (idx)
        resp_pkg::IDX_ECG_CTRL[5:0]: prdata_nxt = {31'h0, hp_r};
        resp_pkg::IDX_RESP_CTRL[5:0]: prdata_nxt = {8'h00, resp_ctrl_r};
        // the 3-bit level field truncates to zero when full, so a full buffer with nothing pending reads like an empty one
        resp_pkg::IDX_STATUS[5:0]: prdata_nxt = {24'h00_0000, 3'(fifo_level), pend_r, overflow_r,
                                                2'(resp_ctrl_r[resp_pkg::F_PATH_LO +: 2]), 1'b0};
        resp_pkg::IDX_SAMPLE[5:0]: prdata_nxt = last_sample_r;
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end
    // a lost sample sets the flag; a status read clears it, but a new loss wins
    if (rd_status) begin
      overflow_nxt = 1'b0;
    end
    if (dump && st_r == ST_RUN && pend_r && !push_ok) begin
      overflow_nxt = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      resp_ctrl_r <= resp_pkg::RESP_CTRL_RST;
      hp_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      overflow_r <= 1'b0;
    end else begin
      resp_ctrl_r <= resp_ctrl_nxt;
      hp_r <= hp_nxt;
      prdata_r <= prdata_nxt;
      overflow_r <= overflow_nxt;
    end
  end

  // ---------------------------------------------------------------
  // carrier and analog steering
  // ---------------------------------------------------------------
  logic enable;
  logic [1:0] path;
  logic [15:0] half_lim;
  logic [15:0] car_cnt_r, car_cnt_nxt;
  logic carrier_r, carrier_nxt;

  assign enable = resp_ctrl_r[resp_pkg::F_ENABLE];
  assign path = resp_ctrl_r[resp_pkg::F_PATH_LO +: 2];
  assign half_lim = half_cycles(resp_ctrl_r[resp_pkg::F_FREQ_LO +: 2], hp_r);

  // >= so a shorter period written mid-run toggles at once instead of wrapping the counter
  always_comb begin
    car_cnt_nxt = car_cnt_r + 16'h0001;
    carrier_nxt = carrier_r;
    if (!enable) begin
      car_cnt_nxt = 16'h0000;
      carrier_nxt = 1'b0;
    end else if (car_cnt_r >= half_lim - 16'h0001) begin
      car_cnt_nxt = 16'h0000;
      carrier_nxt = !carrier_r;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      car_cnt_r <= 16'h0000;
      carrier_r <= 1'b0;
    end else begin
      car_cnt_r <= car_cnt_nxt;
      carrier_r <= carrier_nxt;
    end
  end

  always_comb begin
    analog.drive_en = enable;
    analog.drive_pos = enable && carrier_r;
    analog.drive_neg = enable && !carrier_r;
    analog.sense_sel = enable ? path_onehot(path) : 4'h0;
    analog.ext_cap = resp_ctrl_r[resp_pkg::F_EXT_CAP];
    analog.drive_sel = (enable && !analog.ext_cap) ? path_onehot(path) : 4'h0;
    analog.dac_path_en = enable && analog.ext_cap;
    analog.amp_bypass = resp_ctrl_r[resp_pkg::F_AMP_BYPASS];
    analog.amplitude = resp_ctrl_r[resp_pkg::F_AMP_LO +: 2];
  end

  // ---------------------------------------------------------------
  // demodulation and low-pass
  // ---------------------------------------------------------------
  demod_state_e st_r, st_nxt;
  logic [15:0] dec_cnt_r, dec_cnt_nxt;
  logic signed [31:0] acc_r, acc_nxt, iir_r, iir_nxt, term;

  assign dump = sense.valid && st_r != ST_IDLE && dec_cnt_r == 16'(DECIM - 1);
  assign push_ok = pend_r && fifo_in_ready;

  always_comb begin
    st_nxt = st_r;
    dec_cnt_nxt = dec_cnt_r;
    acc_nxt = acc_r;
    iir_nxt = iir_r;
    term = carrier_r ? 32'(sense.data) : -32'(sense.data);
    case (st_r)
      ST_IDLE: begin
        if (enable) begin
          st_nxt = ST_SETTLE;
        end
      end
      ST_SETTLE, ST_RUN: begin
        if (sense.valid) begin
          dec_cnt_nxt = dec_cnt_r + 16'h0001;
          acc_nxt = acc_r + term;
        end
        if (dump) begin
          dec_cnt_nxt = 16'h0000;
          acc_nxt = 32'sh0000_0000;
          iir_nxt = iir_r + ((acc_r + term - iir_r) >>> LPF_SHIFT);
          st_nxt = ST_RUN;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
    if (!enable || wr_ctrl) begin
      st_nxt = ST_IDLE;
      dec_cnt_nxt = 16'h0000;
      acc_nxt = 32'sh0000_0000;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_r <= ST_IDLE;
      dec_cnt_r <= 16'h0000;
      acc_r <= 32'sh0000_0000;
      iir_r <= 32'sh0000_0000;
    end else begin
      st_r <= st_nxt;
      dec_cnt_r <= dec_cnt_nxt;
      acc_r <= acc_nxt;
      iir_r <= iir_nxt;
    end
  end

  // ---------------------------------------------------------------
  // output staging: only impedance results reach the stream
  // ---------------------------------------------------------------
  always_comb begin
    pend_nxt = pend_r && !push_ok;
    pend_data_nxt = pend_data_r;
    last_sample_nxt = last_sample_r;
    if (dump && st_r == ST_RUN && (!pend_r || push_ok)) begin
      pend_nxt = 1'b1;
      pend_data_nxt = iir_nxt;
      last_sample_nxt = iir_nxt;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pend_r <= 1'b0;
      pend_data_r <= 32'h0000_0000;
      last_sample_r <= 32'h0000_0000;
    end else begin
      pend_r <= pend_nxt;
      pend_data_r <= pend_data_nxt;
      last_sample_r <= last_sample_nxt;
    end
  end

  resp_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .rst(rst),
    .in_valid(pend_r),
    .in_ready(fifo_in_ready),
    .in_data(pend_data_r),
    .out_valid(sample_valid),
    .out_ready(sample_ready),
    .out_data(sample_data),
    .level(fifo_level)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_ctrl_write_lands: assert property (wr_ctrl |=> resp_ctrl_r == $past(pwdata[resp_pkg::RESP_CTRL_W-1:0]))
    else $error("control write not stored");
  a_hp_write_lands: assert property (access && pwrite && mapped && idx == resp_pkg::IDX_ECG_CTRL[5:0] |=>
                                     hp_r == $past(pwdata[resp_pkg::F_HP]))
    else $error("performance bit write not stored");
  a_one_path: assert property (enable |-> $onehot(analog.sense_sel) ##0 analog.sense_sel == path_onehot(path))
    else $error("sense path not one-hot");
  a_path_off_idle: assert property (!enable |-> analog.sense_sel == 4'h0 && !analog.drive_pos)
    else $error("path active while disabled");
  a_internal_drive_pins: assert property (enable && !analog.ext_cap |-> analog.drive_sel == analog.sense_sel)
    else $error("drive pins differ from sense pins");
  a_ext_drive_off: assert property (enable && analog.ext_cap |-> analog.drive_sel == 4'h0 && analog.dac_path_en)
    else $error("external capacitor mode drives sense pins");
  a_bypass_follows: assert property (analog.amp_bypass == resp_ctrl_r[resp_pkg::F_AMP_BYPASS])
    else $error("amplifier bypass not bit 14");
  a_drive_complement: assert property (enable |-> analog.drive_pos != analog.drive_neg)
    else $error("carrier drive phases not complementary");
  a_carrier_half: assert property (enable && $stable(resp_ctrl_r) && $stable(hp_r) && $changed(carrier_r) &&
                                   $past(car_cnt_r) < half_lim |-> $past(car_cnt_r) == half_lim - 16'h0001)
    else $error("carrier half period wrong");
  a_demod_sign: assert property (st_r != ST_IDLE && sense.valid && !dump && enable && !wr_ctrl |=>
                                 acc_r == $past(acc_r) + $past(term))
    else $error("demodulation accumulate wrong");
  a_overflow_sets: assert property (dump && st_r == ST_RUN && pend_r && !fifo_in_ready |=> overflow_r)
    else $error("lost sample not flagged");
  a_settle_dropped: assert property (dump && st_r == ST_SETTLE && !pend_r |=> !pend_r)
    else $error("settling result reached the stream");
  a_dump_at_decim: assert property (dump |-> dec_cnt_r == 16'(DECIM - 1) ##1 dec_cnt_r == 16'h0000)
    else $error("decimation boundary wrong");
  a_stall_holds: assert property (pend_r && !fifo_in_ready |=> pend_r && $stable(pend_data_r))
    else $error("pending sample lost under stall");
  a_unmapped_err: assert property (access && !mapped |-> pslverr ##0 pready)
    else $error("unmapped access not flagged");

  c_carrier_runs: cover property (enable ##1 $rose(carrier_r) ##[1:1000] $fell(carrier_r));
  c_sample_out: cover property (sample_valid && sample_ready);
  c_overflow: cover property ($rose(overflow_r));
  c_external_path: cover property (enable && path == resp_pkg::PATH_EXTERNAL && dump);
  c_hp_carrier: cover property (enable && hp_r && $changed(carrier_r));
endmodule : resp_impedance_ctrl
`default_nettype wire

// *** tb/resp_sense_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------
// electrode pair: one strobed sample every GAP cycles
// ------------------------------------------------
module resp_sense_model #(
  parameter int AMP = 100,
  parameter int GAP = 2
) (
  input wire logic clock,
  input wire logic rst,
  input wire resp_pkg::analog_ctl_s analog,
  output resp_pkg::sense_s sense
);
  int cnt;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      sense <= '0;
    end else begin
      cnt <= (cnt + 1) % GAP;
      sense.valid <= analog.drive_en && cnt == 0;
      if (analog.drive_en && cnt == 0) begin
        // sensed voltage follows the carrier polarity, scaled by impedance
        sense.data <= analog.drive_pos ? 16'(AMP) : -16'(AMP);
      end else begin
        // between strobes the line carries no stale value
        sense.data <= ~sense.data;
      end
    end
  end
endmodule : resp_sense_model
`default_nettype wire

// *** tb/respiration_impedance_control_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module respiration_impedance_control_test;
  localparam int DECIM = 4;
  localparam int AMP = 100;
  logic clock, rst, psel, penable, pwrite, pready, pslverr, sample_valid, sample_ready, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, sample_data, q, v, prev;
  resp_pkg::sense_s sense;
  resp_pkg::analog_ctl_s analog;
  int miscompares, n_compared, n, k, half, expv, s;

  resp_impedance_ctrl #(.DECIM(DECIM)) u_dut (
    .clock(clock), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sense(sense), .analog(analog), .sample_valid(sample_valid),
    .sample_ready(sample_ready), .sample_data(sample_data)
  );

  resp_sense_model #(.AMP(AMP)) u_model (.clock(clock), .rst(rst), .analog(analog), .sense(sense));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ------------------------------------------------
  // helpers
  // ------------------------------------------------
  task print_verdict;
    $display("compared=%0d miscompares=%0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int c;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    c = 0;
    do begin
      @(posedge clock);
      c++;
    end while (pready !== 1'b1 && c < 20);
    if (c >= 20) begin
      miscompares++;
      print_verdict();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task toggle_wait(output int c);
    logic last;
    last = analog.drive_pos;
    c = 0;
    do begin
      @(posedge clock);
      #1;
      c++;
    end while (analog.drive_pos === last && c < 3000);
    if (c >= 3000) begin
      miscompares++;
      print_verdict();
    end
  endtask : toggle_wait

  function automatic logic [12:0] exp_analog(input logic [31:0] w);
    logic [3:0] sel;
    sel = 4'b0001 << w[2:1];
    return {sel, w[5] ? 4'b0000 : sel, w[5], w[0] & w[5], w[14], w[4:3]};
  endfunction : exp_analog

  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    sample_ready = 1'b0;
    miscompares = 0;
    n_compared = 0;
    n = $urandom(74814);
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    #1;
    chk(32'(analog), 32'h0000_0000);
    apb(1'b0, 8'h0C, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    for (int p = 0; p < 8; p++) begin
      v = ($urandom & 32'h00ff_fff9) | 32'h0000_0001 | (32'(p % 4) << 1);
      apb(1'b1, 8'h0C, v);
      apb(1'b0, 8'h0C, 32'h0000_0000);
      chk(q, v & 32'h00ff_ffff);
      chk(32'(analog[12:0]), 32'(exp_analog(v)));
      chk(32'($onehot(analog.sense_sel)), 32'h0000_0001);
      chk(32'(analog.drive_neg), 32'(!analog.drive_pos));
      chk(32'(analog.drive_en), 32'h0000_0001);
    end
    apb(1'b1, 8'h3C, 32'hffff_ffff);
    chk(32'(e), 32'h0000_0001);
    apb(1'b0, 8'h3C, 32'h0000_0000);
    chk({31'h0, e} ^ q, 32'h0000_0001);
    apb(1'b0, 8'h0D, 32'h0000_0000);
    chk(32'(e), 32'h0000_0001);
    apb(1'b0, 8'h0C, 32'h0000_0000);
    chk(q, v & 32'h00ff_ffff);
    // carrier half period for every frequency code under both performance modes
    for (int hp = 0; hp < 2; hp++) begin
      for (int code = 0; code < 4; code++) begin
        apb(1'b1, 8'h04, 32'(hp));
        apb(1'b1, 8'h0C, (32'(code) << 6) | 32'h0000_0001);
        toggle_wait(half);
        toggle_wait(half);
        expv = resp_pkg::CLK_HZ / (2 * (hp == 1 ? resp_pkg::HP_FREQ_HZ[code] : resp_pkg::LP_FREQ_HZ[code]));
        chk(32'(half >= expv - 1 && half <= expv + 1), 32'h0000_0001);
        chk(32'(half >= 781 && half <= 1076), 32'h0000_0001);
      end
    end
    // stream: host stalls until the buffer overflows, then drains
    apb(1'b1, 8'h04, 32'h0000_0000);
    apb(1'b1, 8'h0C, 32'h0000_0001);
    repeat (300) @(posedge clock);
    chk(32'(sample_valid), 32'h0000_0001);
    prev = sample_data;
    repeat (5) @(posedge clock);
    chk(sample_data, prev);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk(32'(q[7:3]), 32'h0000_0003);
    apb(1'b1, 8'h0C, 32'h0000_0000);
    apb(1'b0, 8'h10, 32'h0000_0000);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk(32'(q[3]), 32'h0000_0000);
    n = 0;
    for (k = 0; k < 80; k++) begin
      @(posedge clock);
      if (sample_valid === 1'b1 && sample_ready === 1'b1) begin
        n++;
        s = $signed(sample_data);
        chk(32'(s > 0 && s <= DECIM * AMP), 32'h0000_0001);
      end
      sample_ready <= 1'($urandom % 2);
    end
    chk(32'(n >= 8 && n <= 9), 32'h0000_0001);
    chk(32'(sample_valid), 32'h0000_0000);
    print_verdict();
  end
endmodule : respiration_impedance_control_test
`default_nettype wire
